// ===== clk_mode_pkg.sv
// Constants shared by the CPU clock mode and wait control block
package clk_mode_pkg;

    // Active source codes for the CPU clock divider
    localparam logic [1:0] SRC_MAIN = 2'h0;
    localparam logic [1:0] SRC_SUB  = 2'h1;
    localparam logic [1:0] SRC_FAST = 2'h2;
    localparam logic [1:0] SRC_SLOW = 2'h3;

    // Divider-select pair encodings
    localparam logic [1:0] DIV_SEL_1  = 2'h0;
    localparam logic [1:0] DIV_SEL_2  = 2'h1;
    localparam logic [1:0] DIV_SEL_4  = 2'h2;
    localparam logic [1:0] DIV_SEL_16 = 2'h3;

    // Terminal counts in source edges (ratio minus one)
    localparam logic [3:0] LIM_1  = 4'h0;
    localparam logic [3:0] LIM_2  = 4'h1;
    localparam logic [3:0] LIM_4  = 4'h3;
    localparam logic [3:0] LIM_8  = 4'h7;
    localparam logic [3:0] LIM_16 = 4'hf;

    // Values after reset: slow oscillator, no division
    localparam logic [1:0] RST_SRC      = SRC_SLOW;
    localparam logic [3:0] RST_LIM      = LIM_1;
    localparam logic [1:0] RST_DIV_SEL  = DIV_SEL_1;
    localparam logic       RST_DIV_EIGHT = 1'b0;

    // Wake latency in clk_sys cycles, before and extra per option
    localparam logic [7:0] WAKE_CYC_BASE  = 8'h10;
    localparam logic [7:0] WAKE_CYC_FLASH = 8'h20;
    localparam logic [7:0] WAKE_CYC_VREG  = 8'h40;

    // Power state, one-hot
    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_WAIT = 3'b010,
        ST_WAKE = 3'b100
    } pwr_state_t;

endpackage

// ===== cpu_clock_mode_and_wait_control.sv
// CPU clock source/divider selection, peripheral clock gating and wait mode control
`timescale 1ns/1ps

module cpu_clock_mode_and_wait_control
    import clk_mode_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       main_crystal_clock,
    input  wire logic       sub_crystal_clock,
    input  wire logic       fast_osc_clock,
    input  wire logic       slow_osc_clock,
    input  wire logic       slow_osc_stop,
    input  wire logic       fast_osc_enable,
    input  wire logic       internal_osc_select,
    input  wire logic       internal_osc_system_select,
    input  wire logic       sub_clock_select,
    input  wire logic       osc_stop_irq_enable,
    input  wire logic       wait_periph_clock_stop,
    input  wire logic       internal_power_low_consumption,
    input  wire logic       flash_stop_bit,
    input  wire logic       watchdog_protect,
    input  wire logic       wait_instruction,
    input  wire logic       wait_entry_bit,
    input  wire logic       div_write,
    input  wire logic       div_write_eight,
    input  wire logic [1:0] div_write_sel,
    input  wire logic       wake_clock_sel_0,
    input  wire logic       wake_clock_sel_1,
    input  wire logic       wake_clock_sel_2,
    input  wire logic       irq_serial,
    input  wire logic       serial_ext_clock,
    input  wire logic       irq_key,
    input  wire logic       irq_adc,
    input  wire logic       irq_timer_ra,
    input  wire logic       timer_ra_async_source,
    input  wire logic       irq_timer_rb,
    input  wire logic       irq_timer_rc,
    input  wire logic       irq_timer_re,
    input  wire logic       timer_re_rtc_mode,
    input  wire logic       irq_ext_pin,
    input  wire logic       irq_volt_mon,
    input  wire logic       irq_osc_stop,
    output logic            cpu_clock,
    output logic            watchdog_clock_run,
    output logic [4:0]      periph_clock,
    output logic            timer_ra_osc_clock,
    output logic            fast_osc_undivided_clock,
    output logic            vdet_clock,
    output logic            divide_by_eight_bit,
    output logic            cpu_divider_sel_lo,
    output logic            cpu_divider_sel_hi,
    output logic            in_wait,
    output logic            port_hold,
    output logic            low_supply_current,
    output logic            wake_pulse
);
    import clk_mode_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator pin synchronisers: stages 0,1 sync, stage 2 for edge detect
    // Limitation: an oscillator half period must span three clk_sys cycles
    logic [3:0] sync0;
    logic [3:0] sync1;
    logic [3:0] sync2;
    wire  [3:0] osc_raw = {slow_osc_clock, fast_osc_clock, sub_crystal_clock,
                           main_crystal_clock};
    wire  [3:0] osc_edge;
    wire  [3:0] osc_rise;

    // One synchroniser chain per oscillator
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            // Stage 0 feeds only stage 1
            always_ff @(posedge clk_sys) begin
                if (!rstn) begin
                    sync0[gi] <= 1'b0;
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else begin
                    sync0[gi] <= osc_raw[gi];
                    sync1[gi] <= sync0[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
            assign osc_edge[gi] = sync1[gi] ^ sync2[gi];
            assign osc_rise[gi] = sync1[gi] & ~sync2[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Internal oscillator selection and requested CPU source
    wire slow_run  = ~slow_osc_stop;
    wire int_fast  = fast_osc_enable & internal_osc_select;
    wire int_slow  = slow_run & ~internal_osc_select;
    wire int_level = (int_fast & sync1[2]) | (int_slow & sync1[3]);
    wire int_rise  = (int_fast & osc_rise[2]) | (int_slow & osc_rise[3]);

    wire [1:0] req_src = internal_osc_system_select ? (int_fast ? SRC_FAST : SRC_SLOW)
                       : (sub_clock_select ? SRC_SUB : SRC_MAIN);

    // Divider-select pair, loaded by a software write or by a wake
    logic [1:0] cpu_div_sel;

    wire [3:0] req_lim = divide_by_eight_bit            ? LIM_8  :
                         (cpu_div_sel == DIV_SEL_1)     ? LIM_1  :
                         (cpu_div_sel == DIV_SEL_2)     ? LIM_2  :
                         (cpu_div_sel == DIV_SEL_4)     ? LIM_4  : LIM_16;

    ////////////////////////////////////////////////////////////////////////////
    // Power state machine
    pwr_state_t state;
    pwr_state_t next_state;
    logic [7:0] wake_cnt;
    logic       entry_low_speed;

    wire enter_wait = wait_instruction | wait_entry_bit;

    // With peripheral clocks stopped only self-clocked sources can still request
    // wake eligibility, A/D never wakes
    wire wake_any_clk = irq_serial | irq_key | irq_timer_ra | irq_timer_rb |
                        irq_timer_rc | irq_timer_re | irq_ext_pin | irq_volt_mon |
                        irq_osc_stop;
    wire wake_stopped = (irq_serial & serial_ext_clock) | irq_key |
                        (irq_timer_ra & timer_ra_async_source) |
                        (irq_timer_re & timer_re_rtc_mode) | irq_ext_pin | irq_volt_mon;
    wire wake_req     = wait_periph_clock_stop ? wake_stopped : wake_any_clk;

    // Trade-off: fixed cycle figures stand in for the real restart times
    // latency from flash stop and low-consumption bits
    wire [7:0] wake_lim = WAKE_CYC_BASE
                        + (flash_stop_bit ? WAKE_CYC_FLASH : 8'h00)
                        + (internal_power_low_consumption ? WAKE_CYC_VREG : 8'h00);

    // wake-clock bits: bit 0 enables the update, bits 2:1 the pair
    wire       wake_load = (state == ST_WAIT) & wake_req & wake_clock_sel_0;
    wire [1:0] wake_sel  = {wake_clock_sel_2, wake_clock_sel_1};

    // Reset is the other way out of wait, taken by the synchronous reset
    // Next state decode
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN:  begin
                if (enter_wait) next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (wake_req) next_state = ST_WAKE;
            end
            ST_WAKE: begin
                if (wake_cnt >= wake_lim) next_state = ST_RUN;
            end
        endcase
    end

    // Entry mode is captured once, so a mode write in wait leaves low_supply_current unchanged
    // State, wake counter and entry mode capture
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state           <= ST_RUN;
            wake_cnt        <= 8'h00;
            entry_low_speed <= 1'b0;
        end else begin
            state           <= next_state;
            wake_cnt        <= (state == ST_WAKE) ? wake_cnt + 8'h01 : 8'h00;
            if (state == ST_RUN && enter_wait) begin
                entry_low_speed <= sub_clock_select & ~internal_osc_system_select;
            end
        end
    end

    // Divider bits: software writes, wake overrides (hardware wins)
    // A same-cycle write would otherwise undo the wake clock choice
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            divide_by_eight_bit <= RST_DIV_EIGHT;
            cpu_div_sel         <= RST_DIV_SEL;
        end else if (wake_load) begin
            divide_by_eight_bit <= 1'b0;
            cpu_div_sel         <= wake_sel;
        end else if (div_write) begin
            divide_by_eight_bit <= div_write_eight;
            cpu_div_sel         <= div_write_sel;
        end
    end
    assign cpu_divider_sel_lo = cpu_div_sel[0];
    assign cpu_divider_sel_hi = cpu_div_sel[1];

    ////////////////////////////////////////////////////////////////////////////
    // CPU clock divider, toggles every limit+1 edges of the active source
    // Both source edges count, so limit+1 edges make one half period
    logic [1:0] act_src;
    logic [3:0] act_lim;
    logic [3:0] div_cnt;

    // stop in wait unless osc-stop interrupt enabled
    wire cpu_hold = (state != ST_RUN) & ~((state == ST_WAIT) & osc_stop_irq_enable);
    wire src_edge = (act_src == SRC_MAIN) ? osc_edge[0] :
                    (act_src == SRC_SUB)  ? osc_edge[1] :
                    (act_src == SRC_FAST) ? (osc_edge[2] & fast_osc_enable)
                                          : (osc_edge[3] & slow_run);
    wire at_term  = src_edge & (div_cnt == act_lim);

    // settings load only as the clock goes or stays low
    // Limitation: a stopped active source freezes the divider until it runs again
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cpu_clock <= 1'b0;
            div_cnt   <= 4'h0;
            act_src   <= RST_SRC;
            act_lim   <= RST_LIM;
        end else if (at_term) begin
            div_cnt <= 4'h0;
            if (cpu_clock || cpu_hold) begin
                cpu_clock <= 1'b0;
                act_src   <= req_src;
                act_lim   <= req_lim;
            end else begin
                cpu_clock <= 1'b1;
            end
        end else if (src_edge) begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Peripheral clocks f1, f2, f4, f8, f32 from the system clock
    // Count bit 3 is skipped: bit 4 already divides by 32
    logic [4:0] sys_cnt;
    wire sys_level = internal_osc_system_select ? int_level
                   : (sub_clock_select ? sync1[1] : sync1[0]);
    wire sys_rise  = internal_osc_system_select ? int_rise
                   : (sub_clock_select ? osc_rise[1] : osc_rise[0]);
    wire periph_gate = (state != ST_RUN) & wait_periph_clock_stop;

    // Registered outputs; gating is a trade against the one-cycle output delay
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sys_cnt                  <= 5'h00;
            periph_clock             <= 5'h00;
            timer_ra_osc_clock       <= 1'b0;
            fast_osc_undivided_clock <= 1'b0;
            vdet_clock               <= 1'b0;
        end else begin
            sys_cnt <= sys_rise ? sys_cnt + 5'h01 : sys_cnt;
            periph_clock <= periph_gate ? 5'h00
                          : {sys_cnt[4], sys_cnt[2], sys_cnt[1], sys_cnt[0], sys_level};
            timer_ra_osc_clock       <= (slow_run | fast_osc_enable) & int_level;
            fast_osc_undivided_clock <= fast_osc_enable & sync1[2];
            vdet_clock               <= slow_run & sync1[3];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status outputs
    // Ports stay held through the wake latency, until the CPU runs again
    assign in_wait            = (state == ST_WAIT);
    assign port_hold          = (state != ST_RUN);
    // watchdog follows CPU clock unless protected
    assign watchdog_clock_run = watchdog_protect | ~cpu_hold;
    // Only a wait entered from the sub-crystal mode lowers the supply
    // reduced supply current
    assign low_supply_current = in_wait & entry_low_speed & internal_power_low_consumption;
    // Marks the eligible request that ends wait
    assign wake_pulse         = in_wait & wake_req;

endmodule // cpu_clock_mode_and_wait_control

// ===== cpu_clock_mode_and_wait_control_asserts.sv
// Port-level checks for the CPU clock mode and wait control block
`timescale 1ns/1ps
module cpu_clock_mode_and_wait_control_asserts (
    input wire logic       clk_sys,
    input wire logic       rstn,
    input wire logic       osc_stop_irq_enable,
    input wire logic       wait_periph_clock_stop,
    input wire logic       internal_power_low_consumption,
    input wire logic       flash_stop_bit,
    input wire logic       wait_instruction,
    input wire logic       wait_entry_bit,
    input wire logic       div_write,
    input wire logic       div_write_eight,
    input wire logic [1:0] div_write_sel,
    input wire logic       wake_clock_sel_0,
    input wire logic       wake_clock_sel_1,
    input wire logic       wake_clock_sel_2,
    input wire logic       irq_key,
    input wire logic       cpu_clock,
    input wire logic [4:0] periph_clock,
    input wire logic       divide_by_eight_bit,
    input wire logic       cpu_divider_sel_lo,
    input wire logic       cpu_divider_sel_hi,
    input wire logic       in_wait,
    input wire logic       port_hold,
    input wire logic       wake_pulse
);
    // One clock domain, so clocking and reset are given once
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////
    wait_entry_a: assert property (!port_hold && (wait_instruction || wait_entry_bit)
        |=> in_wait) else $error("wait not entered");
    wake_exit_a: assert property (wake_pulse |=> !in_wait && port_hold)
        else $error("wake did not leave wait");
    key_wake_a: assert property (in_wait && irq_key |-> wake_pulse)
        else $error("key request ignored");
    // Output register lags the state by one edge, so two cycles suffice; the check waits three
    periph_gate_a: assert property ((port_hold && wait_periph_clock_stop)[*3]
        |-> periph_clock == 5'h0) else $error("peripheral clocks not gated");
    cpu_hold_a: assert property (in_wait && !osc_stop_irq_enable && !cpu_clock
        ##1 in_wait && !osc_stop_irq_enable |-> !cpu_clock) else $error("cpu clock ran");
    wake_load_a: assert property (wake_pulse && wake_clock_sel_0 |=> !divide_by_eight_bit
        && cpu_divider_sel_hi == $past(wake_clock_sel_2)
        && cpu_divider_sel_lo == $past(wake_clock_sel_1)) else $error("wake load wrong");
    div_load_a: assert property (div_write && !wake_pulse |=>
        divide_by_eight_bit == $past(div_write_eight)
        && {cpu_divider_sel_hi, cpu_divider_sel_lo} == $past(div_write_sel))
        else $error("divider load wrong");
    wake_delay_a: assert property ($fell(in_wait) && !flash_stop_bit
        && !internal_power_low_consumption |-> ##16 port_hold ##1 !port_hold)
        else $error("wake latency wrong");
endmodule // cpu_clock_mode_and_wait_control_asserts

bind cpu_clock_mode_and_wait_control cpu_clock_mode_and_wait_control_asserts
    i_cpu_clock_mode_and_wait_control_asserts (.*);

// ===== test_cpu_clock_mode_and_wait_control.sv
// Self-checking bench for the CPU clock mode and wait control block
`timescale 1ns/1ps
module test_cpu_clock_mode_and_wait_control;
    logic       clk_sys = 0, rstn = 0, slow_osc_stop = 0, fast_osc_enable = 1;
    logic       main_crystal_clock = 0, sub_crystal_clock = 0, fast_osc_clock = 0;
    logic       slow_osc_clock = 0, internal_osc_select = 0, internal_osc_system_select = 0;
    logic       sub_clock_select = 0, osc_stop_irq_enable = 0, wait_periph_clock_stop = 0;
    logic       internal_power_low_consumption = 0, flash_stop_bit = 0, watchdog_protect = 0;
    logic       wait_instruction = 0, wait_entry_bit = 0, div_write = 0, div_write_eight = 0;
    logic       wake_clock_sel_0 = 0, wake_clock_sel_1 = 0, wake_clock_sel_2 = 0;
    logic       serial_ext_clock = 0, timer_ra_async_source = 0, timer_re_rtc_mode = 0;
    logic [1:0] div_write_sel = 2'h0;
    logic [9:0] irqs = 10'h0;
    wire        irq_serial, irq_key, irq_adc, irq_timer_ra, irq_timer_rb;
    wire        irq_timer_rc, irq_timer_re, irq_ext_pin, irq_volt_mon, irq_osc_stop;
    logic       cpu_clock, watchdog_clock_run, timer_ra_osc_clock, fast_osc_undivided_clock;
    logic       vdet_clock, divide_by_eight_bit, cpu_divider_sel_lo, cpu_divider_sel_hi;
    logic       in_wait, port_hold, low_supply_current, wake_pulse, e;
    logic [4:0] periph_clock;
    logic [2:0] seen;
    int         n_errors = 0, cmp_count = 0, oc = 0, n, lat, k, r;
    int         hp[4] = '{3, 4, 5, 6};
    int         rat[5] = '{1, 2, 4, 16, 8};
    logic [2:0] sb[4] = '{3'h0, 3'h2, 3'h5, 3'h4};

    assign {irq_osc_stop, irq_volt_mon, irq_ext_pin, irq_timer_re, irq_timer_rc,
            irq_timer_rb, irq_timer_ra, irq_adc, irq_key, irq_serial} = irqs;

    cpu_clock_mode_and_wait_control i_cpu_clock_mode_and_wait_control (.*);

    ////////////////////////////////////////////////////////////////////////////
    // Oscillators toggle on a fixed grid, so every CPU clock period is exact
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        oc <= oc + 1;
        main_crystal_clock <= (oc / hp[0]) % 2 == 1;
        sub_crystal_clock <= (oc / hp[1]) % 2 == 1;
        fast_osc_clock <= (oc / hp[2]) % 2 == 1;
        slow_osc_clock <= (oc / hp[3]) % 2 == 1;
    end

    function automatic logic elig(int k, logic stp, logic [2:0] q);
        case (k)
            0: return !stp | q[0];
            2: return 1'b0;
            3: return !stp | q[1];
            4, 5, 9: return !stp;
            6: return !stp | q[2];
            default: return 1'b1;
        endcase
    endfunction

    task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        cmp_count++;
        if (seen_v !== exp_v) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Bounded count of clk_sys cycles up to the next CPU clock rise
    task automatic next_rise(output int c);
        c = 0;
        while (cpu_clock !== 1'b0 && c < 500) begin @(negedge clk_sys); c++; end
        while (cpu_clock !== 1'b1 && c < 500) begin @(negedge clk_sys); c++; end
        if (c >= 500) begin n_errors++; print_verdict(); end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(71958));
        repeat (7) @(posedge clk_sys);
        @(negedge clk_sys);
        check({in_wait, port_hold, wake_pulse, watchdog_clock_run}, 4'h1);
        @(posedge clk_sys);
        rstn <= 1;
        for (int s = 0; s < 4; s++)
            for (int d = 0; d < 5; d++) begin
                @(posedge clk_sys);
                {internal_osc_system_select, sub_clock_select, internal_osc_select} <= sb[s];
                {div_write, div_write_eight, div_write_sel} <= {1'b1, d == 4, 2'(d)};
                @(posedge clk_sys);
                div_write <= 0;
                repeat (3) next_rise(n);
                next_rise(n);
                check(n, rat[d] * 2 * hp[s]);
            end
        $display("clock ratio test done");
        // Random wait entry, refused and accepted wake requests, wake latency
        for (int t = 0; t < 30; t++) begin
            r = $urandom;
            k = $urandom_range(9);
            e = elig(k, r[0], r[8:6]);
            lat = 17 + 32 * r[1] + 64 * r[2];
            @(posedge clk_sys);
            {internal_power_low_consumption, flash_stop_bit, wait_periph_clock_stop} <= r[2:0];
            {wake_clock_sel_2, wake_clock_sel_1, wake_clock_sel_0} <= r[5:3];
            {timer_re_rtc_mode, timer_ra_async_source, serial_ext_clock} <= r[8:6];
            {internal_osc_system_select, sub_clock_select, internal_osc_select} <= sb[r[16:15]];
            watchdog_protect <= r[10];
            // no osc-stop interrupt under internal clock
            osc_stop_irq_enable <= r[9] & !r[16];
            // ratio first, wait entry next, one wake source
            {div_write, div_write_eight, div_write_sel} <= {1'b1, r[13:11]};
            @(posedge clk_sys);
            div_write <= 0;
            {wait_instruction, wait_entry_bit} <= r[14] ? 2'h2 : 2'h1;
            @(posedge clk_sys);
            {wait_instruction, wait_entry_bit} <= 2'h0;
            irqs <= 10'h1 << k;
            @(negedge clk_sys);
            check({in_wait, wake_pulse, watchdog_clock_run, low_supply_current},
                  {1'b1, e, r[10] | (r[9] & !r[16]), r[16:15] == 2'h1 && r[2]});
            check({divide_by_eight_bit, cpu_divider_sel_hi, cpu_divider_sel_lo}, r[13:11]);
            @(posedge clk_sys);
            irqs <= 10'h2;
            @(negedge clk_sys);
            check(in_wait, !e);
            check(periph_clock & {5{r[0]}}, 5'h00);
            @(posedge clk_sys);
            irqs <= 10'h0;
            @(negedge clk_sys);
            check({in_wait, divide_by_eight_bit, cpu_divider_sel_hi, cpu_divider_sel_lo},
                  r[3] ? {2'h0, r[5:4]} : {1'b0, r[13:11]});
            n = 0;
            while (port_hold === 1'b1 && n < 200) begin @(negedge clk_sys); n++; end
            if (n >= 200) begin n_errors++; print_verdict(); end
            check(n, lat - e);
        end
        $display("wait and wake test done");
        // reset ends wait at the next clk_sys edge and restores the divider
        @(posedge clk_sys);
        wait_entry_bit <= 1;
        @(posedge clk_sys);
        wait_entry_bit <= 0;
        rstn <= 0;
        @(negedge clk_sys);
        check(in_wait, 1'b1);
        repeat (3) @(posedge clk_sys);
        rstn <= 1;
        @(negedge clk_sys);
        check({in_wait, port_hold, divide_by_eight_bit, cpu_divider_sel_hi, cpu_divider_sel_lo},
              5'h00);
        $display("reset exit test done");
        for (int g = 0; g < 4; g++) begin
            @(posedge clk_sys);
            {slow_osc_stop, fast_osc_enable, internal_osc_select} <= {g[1:0], g[0]};
            repeat (8) @(posedge clk_sys);
            seen = 3'h0;
            repeat (40) begin
                @(negedge clk_sys);
                seen |= {timer_ra_osc_clock, fast_osc_undivided_clock, vdet_clock};
            end
            check(seen, {!g[1] | g[0], g[0], !g[1]});
        end
        $display("oscillator gating test done");
        print_verdict();
    end
endmodule // test_cpu_clock_mode_and_wait_control
